//--- inc/codec_path_pkg.sv
// Constants and types shared by the codec digital path control logic
package codec_path_pkg;
    // -----------------------------------------------------------------
    // Register map (word index on the control port)
    // -----------------------------------------------------------------
    localparam logic [6:0] ADDR_ANALOGUE_PATH = 7'h04;
    localparam logic [6:0] ADDR_DIGITAL_PATH = 7'h05;
    localparam logic [6:0] ADDR_SAMPLING = 7'h08;
    localparam logic [6:0] ADDR_SOFTWARE_RESET = 7'h0f;
    localparam logic [8:0] RESET_KEY = 9'h000;
    // Reset values
    localparam logic [8:0] APC_RESET = 9'h000;
    localparam logic [8:0] DPC_RESET = 9'h008;
    localparam logic [8:0] SC_RESET = 9'h000;
    // Field positions
    localparam int HPF_DIS_BIT = 0;
    localparam int DEEMP_LSB = 1;
    localparam int SOFT_MUTE_BIT = 3;
    localparam int HOLD_BIT = 4;
    localparam int DAC_MUTE_BIT = 3;
    localparam int DAC_SEL_BIT = 4;
    localparam int RATE_LSB = 2;
    localparam int HALVE_BIT = 6;
    // -----------------------------------------------------------------
    // Filter constants
    // -----------------------------------------------------------------
    localparam int HPF_SHIFT_LOW_RATE = 10;
    localparam int HPF_SHIFT_HIGH_RATE = 11;
    localparam int DEEMP_SHIFT_32K = 1;
    localparam int DEEMP_SHIFT_44K = 2;
    localparam int DEEMP_SHIFT_48K = 3;
    localparam logic [7:0] GAIN_FULL = 8'h80;
    localparam int GAIN_SHIFT = 7;
    localparam logic [8:0] CORE_PER_SAMPLE = 9'h100;
    localparam int FIFO_DEPTH = 16;
    // De-emphasis encodings
    localparam logic [1:0] DEEMP_OFF = 2'h0;
    localparam logic [1:0] DEEMP_32K = 2'h1;
    localparam logic [1:0] DEEMP_44K = 2'h2;
    // Stereo sample pair
    typedef struct packed {
        logic signed [23:0] left;
        logic signed [23:0] right;
    } stereo_t;
    // Software reset sequencer states
    typedef enum logic [2:0] {
        SR_IDLE = 3'b001,
        SR_ARMED = 3'b010,
        SR_ACTIVE = 3'b100
    } sreset_state_t;
endpackage

//--- hw/codec_path_ctrl.sv
// Codec digital path control: registers, ADC high-pass, DAC filter, resets
`timescale 1ns/1ps

// ---------------------------------------------------------------------
// Stream FIFO
// ---------------------------------------------------------------------
module stream_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clr,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rd_q];
    // Storage has no reset; only the pointers and the fill count need a defined value
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end
    // Pointers and fill level
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (clr) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= push ? wr_q + 1'b1 : wr_q;
            rd_q <= pop ? rd_q + 1'b1 : rd_q;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ---------------------------------------------------------------------
// Top level
// ---------------------------------------------------------------------
module codec_path_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic digital_core_supply_good,
    // Decoded control port words and framing pins
    input wire logic reg_wr,
    input wire logic [6:0] reg_addr,
    input wire logic [8:0] reg_data,
    input wire logic three_wire_mode,
    input wire logic control_chip_select_n,
    input wire logic control_sclk,
    input wire logic control_ack_phase,
    // Clocking mode
    input wire logic master_mode,
    input wire logic ext_rate_clock,
    // ADC sample stream
    input wire logic adc_in_valid,
    output logic adc_in_ready,
    input wire codec_path_pkg::stereo_t adc_in_data,
    output logic adc_out_valid,
    input wire logic adc_out_ready,
    output codec_path_pkg::stereo_t adc_out_data,
    // DAC sample stream and line outputs
    input wire logic dac_in_valid,
    output logic dac_in_ready,
    input wire codec_path_pkg::stereo_t dac_in_data,
    output logic signed [23:0] left_line_output,
    output logic signed [23:0] right_line_output,
    // Status
    output logic core_tick,
    output logic sample_tick,
    output logic device_in_reset,
    output logic [8:0] digital_path_status
);
    logic [8:0] apc_q, dpc_q, sc_q;
    logic por_q, sclk_q, cs_q, rate_q;
    codec_path_pkg::sreset_state_t sr_q, sr_d;
    logic signed [23:0] est_q [2];
    logic signed [23:0] deemp_q [2];
    logic signed [23:0] line_q [2];
    logic [7:0] gain_q;
    logic core_q, fs_tick_q, dac_rdy_q;
    logic [8:0] fs_cnt_q;
    logic hold_q;
    logic signed [23:0] adc_x [2], adc_y [2], dac_x [2], dac_y [2];
    logic signed [23:0] scaled [2];
    codec_path_pkg::stereo_t adc_res;
    // -----------------------------------------------------------------
    // Reset sources
    // -----------------------------------------------------------------
    // Supply drop and software reset both clear state synchronously
    wire soft_rst = (sr_q == codec_path_pkg::SR_ACTIVE);
    wire int_rst = por_q || soft_rst;
    wire cs_rise = control_chip_select_n && !cs_q;
    wire sclk_rise = control_sclk && !sclk_q;
    wire rst_wr = reg_wr && (reg_addr == codec_path_pkg::ADDR_SOFTWARE_RESET)
        && (reg_data == codec_path_pkg::RESET_KEY);
    // Sequencer: arm on the zero write, fire on the framing edge
    always_comb begin
        sr_d = sr_q;
        case (sr_q)
            codec_path_pkg::SR_IDLE: begin
                if (rst_wr) begin
                    sr_d = codec_path_pkg::SR_ARMED;
                end
            end
            codec_path_pkg::SR_ARMED: begin
                if (three_wire_mode ? cs_rise : control_ack_phase) begin
                    sr_d = codec_path_pkg::SR_ACTIVE;
                end
            end
            codec_path_pkg::SR_ACTIVE: begin
                if (three_wire_mode ? sclk_rise : !control_ack_phase) begin
                    sr_d = codec_path_pkg::SR_IDLE;
                end
            end
            default: sr_d = codec_path_pkg::SR_IDLE;
        endcase
    end
    // The sequencer is not cleared by the reset it produces
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sr_q <= codec_path_pkg::SR_IDLE;
            por_q <= 1'b1;
            cs_q <= 1'b1;
            sclk_q <= 1'b0;
        end else begin
            sr_q <= sr_d;
            por_q <= !digital_core_supply_good;
            cs_q <= control_chip_select_n;
            sclk_q <= control_sclk;
        end
    end
    // -----------------------------------------------------------------
    // Control registers
    // -----------------------------------------------------------------
    wire wr_apc = reg_wr && (reg_addr == codec_path_pkg::ADDR_ANALOGUE_PATH);
    wire wr_dpc = reg_wr && (reg_addr == codec_path_pkg::ADDR_DIGITAL_PATH);
    wire wr_sc = reg_wr && (reg_addr == codec_path_pkg::ADDR_SAMPLING);
    wire hpf_off = dpc_q[codec_path_pkg::HPF_DIS_BIT];
    wire hold_sel = dpc_q[codec_path_pkg::HOLD_BIT];
    wire [1:0] deemp_sel = dpc_q[codec_path_pkg::DEEMP_LSB +: 2];
    wire soft_mute = dpc_q[codec_path_pkg::SOFT_MUTE_BIT];
    wire dac_sel = apc_q[codec_path_pkg::DAC_SEL_BIT];
    wire dac_mute = apc_q[codec_path_pkg::DAC_MUTE_BIT];
    wire halve = sc_q[codec_path_pkg::HALVE_BIT];
    // Writes during a reset are dropped, the device is not listening
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            apc_q <= codec_path_pkg::APC_RESET;
            dpc_q <= codec_path_pkg::DPC_RESET;
            sc_q <= codec_path_pkg::SC_RESET;
        end else if (int_rst) begin
            apc_q <= codec_path_pkg::APC_RESET;
            dpc_q <= codec_path_pkg::DPC_RESET;
            sc_q <= codec_path_pkg::SC_RESET;
        end else begin
            apc_q <= wr_apc ? reg_data : apc_q;
            dpc_q <= wr_dpc ? reg_data : dpc_q;
            sc_q <= wr_sc ? reg_data : sc_q;
        end
    end
    // -----------------------------------------------------------------
    // Core clock and sample rate
    // -----------------------------------------------------------------
    // Core runs every cycle, or every other one when halved
    wire core_next = halve ? !core_q : 1'b1;
    wire fs_wrap = (fs_cnt_q == codec_path_pkg::CORE_PER_SAMPLE - 9'h001);
    wire fs_next = master_mode ? (core_q && fs_wrap)
        : (ext_rate_clock && !rate_q);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            core_q <= 1'b1;
            fs_cnt_q <= '0;
            fs_tick_q <= 1'b0;
            rate_q <= 1'b0;
        end else if (int_rst) begin
            core_q <= 1'b1;
            fs_cnt_q <= '0;
            fs_tick_q <= 1'b0;
            rate_q <= ext_rate_clock;
        end else begin
            core_q <= core_next;
            fs_cnt_q <= !core_q ? fs_cnt_q : (fs_wrap ? '0 : fs_cnt_q + 1'b1);
            fs_tick_q <= fs_next;
            rate_q <= ext_rate_clock;
        end
    end
    // -----------------------------------------------------------------
    // ADC high-pass and offset hold
    // -----------------------------------------------------------------
    function automatic logic signed [23:0] sat24(logic signed [24:0] v);
        if (v > 25'sh07f_ffff) begin
            sat24 = 24'sh7f_ffff;
        end else if (v < -25'sh080_0000) begin
            sat24 = -24'sh80_0000;
        end else begin
            sat24 = v[23:0];
        end
    endfunction
    // Slower tracking at the higher rates keeps the corner fixed in Hz
    wire rate_hi = sc_q[codec_path_pkg::RATE_LSB + 3];
    wire [3:0] hpf_k = rate_hi ? 4'(codec_path_pkg::HPF_SHIFT_HIGH_RATE)
        : 4'(codec_path_pkg::HPF_SHIFT_LOW_RATE);
    wire adc_take = adc_in_valid && adc_in_ready;
    assign adc_x[0] = adc_in_data.left;
    assign adc_x[1] = adc_in_data.right;
    wire use_est = !hpf_off || hold_sel;
    for (genvar c = 0; c < 2; c++) begin : g_hpf
        wire signed [24:0] err = 25'(adc_x[c]) - 25'(est_q[c]);
        assign adc_y[c] = use_est ? sat24(err) : adc_x[c];
        // Estimate moves only while the filter is enabled
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                est_q[c] <= '0;
            end else if (int_rst || (hpf_off && !hold_sel)) begin
                est_q[c] <= '0;
            end else if (adc_take && !hpf_off) begin
                est_q[c] <= est_q[c] + 24'(err >>> hpf_k);
            end
        end
    end
    assign adc_res.left = adc_y[0];
    assign adc_res.right = adc_y[1];
    // Output buffer; a stalled reader pushes back on the ADC source
    stream_fifo #(
        .WIDTH(48),
        .DEPTH(codec_path_pkg::FIFO_DEPTH)
    ) u_adc_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .clr(int_rst),
        .in_valid(adc_in_valid),
        .in_ready(adc_in_ready),
        .in_data(adc_res),
        .out_valid(adc_out_valid),
        .out_ready(adc_out_ready),
        .out_data(adc_out_data)
    );
    // -----------------------------------------------------------------
    // DAC de-emphasis, soft mute and line outputs
    // -----------------------------------------------------------------
    wire dac_take = dac_in_valid && dac_rdy_q;
    wire [1:0] de_k = (deemp_sel == codec_path_pkg::DEEMP_32K)
        ? 2'(codec_path_pkg::DEEMP_SHIFT_32K)
        : (deemp_sel == codec_path_pkg::DEEMP_44K)
        ? 2'(codec_path_pkg::DEEMP_SHIFT_44K)
        : 2'(codec_path_pkg::DEEMP_SHIFT_48K);
    wire silent = !dac_sel || dac_mute || (gain_q == 8'h00);
    assign dac_x[0] = dac_in_data.left;
    assign dac_x[1] = dac_in_data.right;
    for (genvar c = 0; c < 2; c++) begin : g_dac
        wire signed [24:0] step = 25'(dac_x[c]) - 25'(deemp_q[c]);
        wire signed [24:0] lp = 25'(deemp_q[c]) + (step >>> de_k);
        wire signed [32:0] prod = 33'(deemp_q[c]) * $signed({1'b0, gain_q});
        assign dac_y[c] = (deemp_sel == codec_path_pkg::DEEMP_OFF)
            ? dac_x[c] : sat24(lp);
        assign scaled[c] = 24'(prod >>> codec_path_pkg::GAIN_SHIFT);
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                deemp_q[c] <= '0;
                line_q[c] <= '0;
            end else if (int_rst) begin
                deemp_q[c] <= '0;
                line_q[c] <= '0;
            end else begin
                deemp_q[c] <= dac_take ? dac_y[c] : deemp_q[c];
                line_q[c] <= silent ? '0 : scaled[c];
            end
        end
    end
    // Gain walks one step per accepted sample, so 128 samples end to end
    wire ramp_dn = soft_mute && (gain_q != 8'h00);
    wire ramp_up = !soft_mute && (gain_q != codec_path_pkg::GAIN_FULL);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gain_q <= 8'h00;
            dac_rdy_q <= 1'b0;
            hold_q <= 1'b0;
        end else if (int_rst) begin
            gain_q <= 8'h00;
            dac_rdy_q <= 1'b0;
            hold_q <= 1'b0;
        end else begin
            dac_rdy_q <= 1'b1;
            hold_q <= hpf_off && hold_sel;
            if (dac_take && ramp_dn) begin
                gain_q <= gain_q - 8'h01;
            end else if (dac_take && ramp_up) begin
                gain_q <= gain_q + 8'h01;
            end
        end
    end
    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    assign dac_in_ready = dac_rdy_q;
    assign left_line_output = line_q[0];
    assign right_line_output = line_q[1];
    assign core_tick = core_q;
    assign sample_tick = fs_tick_q;
    assign device_in_reset = por_q || soft_rst;
    assign digital_path_status = dpc_q;
    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    a_hpf_bypass: assert property (@(posedge clk) disable iff (!rst_b)
        (hpf_off && !hold_sel && !int_rst) |-> (adc_res == adc_in_data))
        else $error("bypassed high-pass altered the sample");
    a_offset_frozen: assert property (@(posedge clk) disable iff (!rst_b)
        (hold_q && hpf_off && hold_sel && !int_rst)
        |-> (est_q[0] == $past(est_q[0])))
        else $error("held offset moved while filter disabled");
    a_offset_clear: assert property (@(posedge clk) disable iff (!rst_b)
        (hpf_off && !hold_sel) |=> (est_q[0] == '0))
        else $error("offset not cleared without hold");
    a_reset_default: assert property (@(posedge clk) disable iff (!rst_b)
        int_rst |=> (dpc_q == 9'h008 && apc_q == 9'h000))
        else $error("registers not at defaults after reset");
    a_reset_three_wire: assert property (@(posedge clk) disable iff (!rst_b)
        (sr_q == codec_path_pkg::SR_ARMED && three_wire_mode && cs_rise)
        |=> soft_rst)
        else $error("software reset missed select rising edge");
    a_reset_release: assert property (@(posedge clk) disable iff (!rst_b)
        (soft_rst && three_wire_mode && sclk_rise) |=> !soft_rst)
        else $error("software reset not released on clock rise");
    a_reset_two_wire: assert property (@(posedge clk) disable iff (!rst_b)
        (soft_rst && !three_wire_mode && control_ack_phase)
        |=> soft_rst)
        else $error("software reset ended during acknowledge");
    a_nonzero_ignored: assert property (@(posedge clk) disable iff (!rst_b)
        (sr_q == codec_path_pkg::SR_IDLE && reg_wr && !rst_wr)
        |=> (sr_q == codec_path_pkg::SR_IDLE))
        else $error("non-zero reset write took effect");
    a_line_silent: assert property (@(posedge clk) disable iff (!rst_b)
        (!dac_sel || dac_mute) |=> (line_q[0] == '0 && line_q[1] == '0))
        else $error("line output not silenced");
    a_gain_ramp: assert property (@(posedge clk) disable iff (!rst_b)
        (dac_take && ramp_dn && !int_rst)
        |=> (gain_q == $past(gain_q) - 8'h01))
        else $error("soft mute gain did not step down by one");
    a_core_halve: assert property (@(posedge clk) disable iff (!rst_b)
        (halve && $past(halve) && !int_rst && !$past(int_rst))
        |-> (core_q != $past(core_q)))
        else $error("halved core tick did not alternate");
endmodule

//--- verif/host_model.sv
// Host model: decoded control words and control framing pins
`timescale 1ns/1ps
module host_model (
    // Clock
    input wire logic clk,
    // Control port and framing pins
    output logic reg_wr,
    output logic [6:0] reg_addr,
    output logic [8:0] reg_data,
    output logic control_chip_select_n,
    output logic control_sclk,
    output logic control_ack_phase
);
    // Pins idle with select high and the serial clock still
    initial begin
        reg_wr = 1'b0;
        reg_addr = 7'h00;
        reg_data = 9'h000;
        control_chip_select_n = 1'b1;
        control_sclk = 1'b0;
        control_ack_phase = 1'b0;
    end
    // One word per pulse; idle lines show the inverse of the last word
    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        @(posedge clk);
        #1 control_chip_select_n = 1'b0;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_data = d;
        @(posedge clk);
        #1 reg_wr = 1'b0;
        reg_addr = ~a;
        reg_data = ~d;
        control_chip_select_n = 1'b1;
    endtask
    // One serial clock period after a framed write
    task automatic sclk_pulse;
        @(posedge clk);
        #1 control_sclk = 1'b1;
        @(posedge clk);
        #1 control_sclk = 1'b0;
    endtask
    // Acknowledge bit of the two-wire frame
    task automatic ack(input logic v);
        @(posedge clk);
        #1 control_ack_phase = v;
    endtask
    // A 512fs master clock needs the core divider set
    task automatic halve(input logic on);
        wr(7'h08, {2'b00, on, 6'h00});
    endtask
endmodule

//--- verif/codec_path_ctrl_bench.sv
// Self-checking bench for the codec digital path control block
`timescale 1ns/1ps
module codec_path_ctrl_bench;
    logic clk = 1'b0, rst_b = 1'b0, sup = 1'b1, three = 1'b1, mst = 1'b1;
    logic erc = 1'b0, ai_v = 1'b0, ao_r = 1'b1, di_v = 1'b0;
    logic wr, csn, sclk, ackp, ai_r, ao_v, di_r, ct, st, dir, mute, sel;
    logic [6:0] ad;
    logic [8:0] dat, stat;
    logic signed [23:0] lo, ro;
    codec_path_pkg::stereo_t ai_d = '0, ao_d, di_d = '0;
    logic [47:0] q[$];
    int num_errors = 0, check_count = 0, est_l, est_r, gain, sh, c, n;
    int dl, dr, de;
    // Clock at 50 MHz
    always #10 clk = ~clk;
    host_model host_model_inst (.clk(clk), .reg_wr(wr), .reg_addr(ad),
        .reg_data(dat), .control_chip_select_n(csn), .control_sclk(sclk),
        .control_ack_phase(ackp));
    codec_path_ctrl codec_path_ctrl_inst (.clk(clk), .rst_b(rst_b),
        .digital_core_supply_good(sup), .reg_wr(wr), .reg_addr(ad),
        .reg_data(dat), .three_wire_mode(three), .control_chip_select_n(csn),
        .control_sclk(sclk), .control_ack_phase(ackp), .master_mode(mst),
        .ext_rate_clock(erc), .adc_in_valid(ai_v), .adc_in_ready(ai_r),
        .adc_in_data(ai_d), .adc_out_valid(ao_v), .adc_out_ready(ao_r),
        .adc_out_data(ao_d), .dac_in_valid(di_v), .dac_in_ready(di_r),
        .dac_in_data(di_d), .left_line_output(lo), .right_line_output(ro),
        .core_tick(ct), .sample_tick(st), .device_in_reset(dir),
        .digital_path_status(stat));
    // -----------------------------------------------------------------
    // Shared tasks
    // -----------------------------------------------------------------
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wrap_up;
        if (num_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Holds valid until the edge that sees ready
    task automatic adc(input int l, input int r);
        step(1); // Let an edge pass between two requests
        ai_d = {l[23:0], r[23:0]};
        ai_v = 1'b1;
        for (n = 0; ai_r !== 1'b1 && n < 40; n++) step(1);
        step(1);
        ai_v = 1'b0;
    endtask
    // Old estimate is subtracted, then it moves by a 2^-sh step
    task automatic adc_chk(input int l, input int r, input bit upd);
        adc(l, r);
        for (n = 0; ao_v !== 1'b1 && n < 10; n++) step(1);
        chk(ao_d, {24'(l - est_l), 24'(r - est_r)});
        if (upd) begin
            est_l += (l - est_l) >>> sh;
            est_r += (r - est_r) >>> sh;
        end
    endtask
    // Gain moves one step per sample; outputs settle one edge after the accepting edge
    task automatic dac(input int x, input int y);
        logic [47:0] ex;
        di_d = {x[23:0], y[23:0]};
        di_v = 1'b1;
        for (n = 0; di_r !== 1'b1 && n < 40; n++) step(1);
        step(1);
        di_v = 1'b0;
        gain = mute ? (gain > 0 ? gain - 1 : 0) : (gain < 128 ? gain + 1 : 128);
        // First-order de-emphasis model, bypassed when de is zero
        dl = de ? dl + ((x - dl) >>> de) : x;
        dr = de ? dr + ((y - dr) >>> de) : y;
        ex = {24'((dl * gain) >>> 7), 24'((dr * gain) >>> 7)};
        step(3);
        chk({lo, ro}, sel ? ex : '0);
    endtask
    // Hang guard well beyond the expected run length
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        wrap_up;
    end
    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        void'($urandom(32'h2461));
        repeat (12) @(posedge clk);
        #1 rst_b = 1'b1;
        step(2);
        chk({di_r, dir, stat}, 11'h408);
        for (int k = 0; k < 4; k++) begin
            host_model_inst.wr(7'h05, 9'(2 * k));
            chk(stat, 9'(2 * k));
        end
        {est_l, est_r, sh} = {32'd0, 32'd0, 32'd10};
        for (int k = 0; k < 23; k++) begin
            if (k == 15) host_model_inst.wr(7'h05, 9'h011);
            if (k == 19) host_model_inst.wr(7'h05, 9'h001);
            if (k == 19) {est_l, est_r} = 64'd0;
            adc_chk(100000 + $urandom % 90000, -200000, k < 15);
        end
        host_model_inst.wr(7'h05, 9'h000);
        host_model_inst.wr(7'h08, 9'h020);
        sh = 11;
        repeat (4) adc_chk(150000, -150000, 1);
        host_model_inst.wr(7'h05, 9'h001);
        {est_l, est_r} = 64'd0;
        ao_r = 1'b0;
        for (c = 0; ai_r === 1'b1 && c < 20; c++) begin
            q.push_back(48'({$urandom, $urandom}));
            adc(q[c][47:24], q[c][23:0]);
        end
        chk({c, ai_r}, {32'd16, 1'b0});
        for (n = 0; q.size() > 0 && n < 300; n++) begin
            ao_r = 1'($urandom);
            if (ao_v === 1'b1 && ao_r) chk(ao_d, q.pop_front());
            step(1);
        end
        ao_r = 1'b1;
        step(1);
        chk(ao_v, 0);
        {mute, sel, gain} = {1'b0, 1'b1, 32'd0};
        host_model_inst.wr(7'h04, 9'h010);
        for (int k = 0; k < 280; k++) begin
            if (k == 100) host_model_inst.wr(7'h05, 9'h003);
            if (k == 130) host_model_inst.wr(7'h05, 9'h00d);
            mute = (k >= 130 && k < 262);
            if (k == 262) host_model_inst.wr(7'h05, 9'h007);
            de = (k < 100) ? 0 : (k < 130) ? 1 : (k < 262) ? 2 : 3;
            if (k == 270) host_model_inst.wr(7'h04, 9'h018);
            sel = k < 270;
            dac($urandom % 8000000 - 4000000, -3000000);
        end
        for (int h = 1; h >= 0; h--) begin
            c = 0;
            repeat (16) begin
                c += ct;
                step(1);
            end
            chk(c, h ? 16 : 8);
            host_model_inst.halve(0);
            if (h) host_model_inst.halve(1);
        end
        host_model_inst.halve(0);
        c = 0;
        repeat (600) begin
            c += st;
            step(1);
        end
        chk(c == 2 || c == 3, 1);
        mst = 1'b0;
        step(1); // Flush a master tick already in flight
        c = 0;
        for (int k = 0; k < 60; k++) begin
            erc = (k / 6) % 2;
            c += st;
            step(1);
        end
        chk(c, 5);
        host_model_inst.wr(7'h05, 9'h011);
        host_model_inst.wr(7'h0f, 9'h100);
        host_model_inst.sclk_pulse;
        step(2);
        chk({dir, stat}, 10'h011);
        host_model_inst.wr(7'h0f, 9'h000);
        step(4);
        chk({di_r, dir, stat}, 11'h208);
        host_model_inst.sclk_pulse;
        step(2);
        chk(dir, 0);
        three = 1'b0;
        host_model_inst.wr(7'h05, 9'h011);
        host_model_inst.wr(7'h0f, 9'h000);
        host_model_inst.ack(1'b1);
        step(3);
        chk(dir, 1);
        host_model_inst.ack(1'b0);
        step(2);
        chk({dir, stat}, 10'h008);
        host_model_inst.wr(7'h05, 9'h011);
        sup = 1'b0;
        step(3);
        chk({dir, stat}, 10'h208);
        sup = 1'b1;
        step(4);
        chk(dir, 0);
        wrap_up;
    end
endmodule
